//--- hw/cyclic_serial_word_store.sv
// Top of the cyclic serial word store: blocks 1..21, constants, accumulator.
// Assumes a control unit that offers 32-bit instruction words on cmd_word.
`timescale 1ns/100ps
module cyclic_serial_word_store #(
	parameter int BIT_CLKS = serial_store_pkg::BIT_CLKS
) (
	input  wire logic                  mclk,          // 20 MHz clock
	input  wire logic                  rst,           // Async reset, high
	input  wire serial_store_pkg::cmd_t cmd_word,     // Offered instruction
	input  wire logic                  cmd_valid,     // Instruction offered
	output logic                       cmd_ready,     // Instruction taken now
	output logic                       busy,          // Move in progress
	output logic                       bit_stb,       // Bit period strobe
	output logic [4:0]                 bit_idx,       // Bit within slot
	output logic [4:0]                 slot,          // Current slot
	output logic                       out_bit_ff,    // Source line, one bit late
	output logic [31:0]                instr_word_ff, // Instruction store word
	output logic [31:0]                short_accumulator_ff // Short accumulator
);
	import serial_store_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	move_state_t state_ff;
	move_state_t nxt_state;
	logic [4:0]  src_ff;
	logic [4:0]  dst_ff;
	logic        carry_ff;
	logic        nxt_carry;
	logic [NUM_BLOCKS:1] blk_rd;
	logic [NUM_BLOCKS:1] blk_wr;
	logic [4:0]  next_slot;
	logic        slot_ok;
	logic        take;
	logic        moving;
	logic        src_bit;
	logic        acc_bit;
	logic        add_op;
	logic        sub_op;
	logic        arith_in;
	logic        carry_in;
	logic        sum_bit;
	logic        acc_wr;
	logic        acc_new;

	// Constant word bit for a source code
	// fixed constant words
	function automatic logic const_bit(input logic [4:0] src, input logic [4:0] b);
		unique case (src)
			SRC_CONST_LOW:  return BIT_ONE_WORD[b];
			SRC_CONST_MID:  return BIT_SEVENTEEN_WORD[b];
			SRC_CONST_TOP:  return BIT_THIRTY_TWO_WORD[b];
			SRC_CONST_ONES: return ALL_ONES_WORD[b];
			default:        return ZERO_WORD[b];
		endcase
	endfunction : const_bit

	// Source code that reaches a numbered block
	function automatic logic is_block(input logic [4:0] code, input int blk);
		return code == 5'(blk);
	endfunction : is_block

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	slot_timer #(
		.BIT_CLKS (BIT_CLKS)
	) u_timer (
		.mclk    (mclk),
		.rst     (rst),
		.bit_stb (bit_stb),
		.bit_idx (bit_idx),
		.slot    (slot)
	);

	// ----------------------------------------
	// Command intake
	// ----------------------------------------
	// wait for the named slot
	assign next_slot = slot + 5'h01;
	assign slot_ok   = !cmd_word.slot_qual || (cmd_word.slot == next_slot);
	// take source and destination at slot boundary
	assign cmd_ready = bit_stb && (bit_idx == LAST_BIT) && slot_ok;
	assign take      = cmd_valid && cmd_ready;
	assign moving    = (state_ff == ST_MOVE);
	assign busy      = moving;

	// Move state for the coming slot
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_MOVE;
				end
			end
			ST_MOVE: begin
				if (bit_stb && bit_idx == LAST_BIT && !take) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// every instruction enters the instruction store
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff      <= ST_IDLE;
			src_ff        <= 5'h00;
			dst_ff        <= 5'h00;
			instr_word_ff <= ZERO_WORD;
		end else begin
			state_ff <= nxt_state;
			if (take) begin
				src_ff        <= cmd_word.src;
				dst_ff        <= cmd_word.dst;
				instr_word_ff <= cmd_word;
			end
		end
	end

	// ----------------------------------------
	// Storage blocks
	// ----------------------------------------
	// one source and one destination per block
	for (genvar b = 1; b <= NUM_BLOCKS; b++) begin : g_blk
		assign blk_wr[b] = moving && is_block(dst_ff, b);
		if (b == BLK_SHORT_ACC) begin : g_acc
			assign blk_rd[b] = acc_bit;
		end else begin : g_store
			// long, quad, double and single depths
			word_block #(
				.WORDS (block_words(b))
			) u_blk (
				.mclk    (mclk),
				.rst     (rst),
				.bit_stb (bit_stb),
				.bit_idx (bit_idx),
				.slot    (slot),
				.wr_en   (blk_wr[b]),
				.wr_bit  (src_bit),
				.rd_bit  (blk_rd[b])
			);
		end
	end

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	// constants open in every slot
	assign src_bit = (src_ff >= SRC_CONST_LOW) ? const_bit(src_ff, bit_idx)
		: (src_ff >= 5'h01 && src_ff <= 5'(NUM_BLOCKS)) ? blk_rd[src_ff] : 1'b0;

	// Registered copy of the source line
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_bit_ff <= 1'b0;
		end else if (bit_stb) begin
			out_bit_ff <= moving ? src_bit : 1'b0;
		end
	end

	// ----------------------------------------
	// Short accumulator
	// ----------------------------------------
	// lsb first, carry seeded at bit 1
	assign acc_bit  = short_accumulator_ff[bit_idx];
	// add and subtract in any slot
	assign add_op   = moving && (dst_ff == DST_ADD);
	assign sub_op   = moving && (dst_ff == DST_SUB);
	assign arith_in = sub_op ? ~src_bit : src_bit;
	assign carry_in = (bit_idx == FIRST_BIT) ? sub_op : carry_ff;
	assign sum_bit  = acc_bit ^ arith_in ^ carry_in;
	// carry past bit 32 is dropped
	assign nxt_carry = (acc_bit & arith_in) | (carry_in & (acc_bit ^ arith_in));
	assign acc_wr   = blk_wr[BLK_SHORT_ACC] || add_op || sub_op;
	// destination 13 is a plain load
	assign acc_new  = blk_wr[BLK_SHORT_ACC] ? src_bit : sum_bit;

	// subtract by adding the complement plus one
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			short_accumulator_ff <= ZERO_WORD;
			carry_ff             <= 1'b0;
		end else if (bit_stb) begin
			carry_ff <= nxt_carry;
			if (acc_wr) begin
				short_accumulator_ff[bit_idx] <= acc_new;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_take_plain;
		take && !cmd_word.slot_qual;
	endsequence

	sequence s_take_named;
		take && cmd_word.slot_qual;
	endsequence

	sequence s_move_bit;
		bit_stb && moving;
	endsequence

	AST_TAKE_AT_BOUNDARY: assert property (s_take_plain |=>
		moving && bit_idx == FIRST_BIT && src_ff == $past(cmd_word.src))
		else $error("plain command not started at slot start");
	AST_NAMED_SLOT: assert property (s_take_named |=>
		slot == $past(cmd_word.slot) && moving)
		else $error("named command started in wrong slot");
	AST_INSTR_STORE: assert property (take |=> instr_word_ff == $past(cmd_word))
		else $error("instruction store missed a command");
	AST_CONST_ONES: assert property ((s_move_bit ##0 src_ff == SRC_CONST_ONES) |=> out_bit_ff)
		else $error("all ones source gave a zero");
	AST_CONST_LOW: assert property ((s_move_bit ##0 src_ff == SRC_CONST_LOW) |=>
		out_bit_ff == ($past(bit_idx) == FIRST_BIT))
		else $error("bit one source wrong");
	AST_ACC_LOAD: assert property ((s_move_bit ##0 dst_ff == BLK_SHORT_ACC) |=>
		short_accumulator_ff[$past(bit_idx)] == $past(src_bit))
		else $error("load of short accumulator wrong");
	AST_ACC_ADD: assert property ((s_move_bit ##0 dst_ff == DST_ADD) |=>
		short_accumulator_ff[$past(bit_idx)] == ($past(acc_bit) ^ $past(src_bit) ^ $past(carry_in)))
		else $error("serial add bit wrong");
	AST_ACC_SUB: assert property ((s_move_bit ##0 dst_ff == DST_SUB && bit_idx == FIRST_BIT) |=>
		short_accumulator_ff[$past(bit_idx)] == ($past(acc_bit) ^ ~$past(src_bit) ^ 1'b1))
		else $error("serial subtract first bit wrong");
	AST_MOVE_LENGTH: assert property ((s_take_plain ##1 !cmd_valid [*1]) |-> moving [*8])
		else $error("move ended early");

	// ----------------------------------------
	// Command and move checks
	// ----------------------------------------
	sequence s_slot_end;
		bit_stb && bit_idx == LAST_BIT;
	endsequence

	sequence s_idle_bit;
		bit_stb && !moving;
	endsequence

	// Acceptance and slot framing
	AST_READY_AT_END: assert property (cmd_ready |-> bit_stb && bit_idx == LAST_BIT)
		else $error("command accepted inside a slot");
	AST_NAMED_WAIT: assert property ((cmd_word.slot_qual && cmd_word.slot != next_slot) |-> !cmd_ready)
		else $error("named command accepted before its slot");
	AST_MOVE_ONE_SLOT: assert property ((s_slot_end ##0 take) |=>
		moving && bit_idx == FIRST_BIT && slot == $past(next_slot))
		else $error("move did not start in the following slot");
	AST_MOVE_STOP: assert property ((s_slot_end ##0 !take) |=> !moving)
		else $error("move ran past its slot");
	AST_SRC_HELD: assert property ((moving && !take) |=> $stable(src_ff) && $stable(dst_ff))
		else $error("source or destination changed during a move");
	AST_INSTR_HOLD: assert property (!take |=> $stable(instr_word_ff))
		else $error("instruction store changed without a command");

	// Destination gating
	AST_NO_WR_IDLE: assert property (!moving |-> (blk_wr == '0) && !acc_wr)
		else $error("destination open with no move running");
	AST_DST_ONE_HOT: assert property ($onehot0(blk_wr))
		else $error("more than one destination open");

	// Source line content
	AST_IDLE_QUIET: assert property (s_idle_bit |=> !out_bit_ff)
		else $error("source line active with no move");
	AST_OUT_FOLLOWS: assert property (s_move_bit |=> out_bit_ff == $past(src_bit))
		else $error("source line lost a bit");
	AST_CONST_MID: assert property ((s_move_bit ##0 src_ff == SRC_CONST_MID) |=>
		out_bit_ff == ($past(bit_idx) == 5'(WORD_BITS / 2)))
		else $error("bit seventeen source wrong");
	AST_CONST_TOP: assert property ((s_move_bit ##0 src_ff == SRC_CONST_TOP) |=>
		out_bit_ff == ($past(bit_idx) == LAST_BIT))
		else $error("bit thirty two source wrong");
	AST_CONST_ZERO: assert property ((s_move_bit ##0 src_ff == SRC_CONST_ZERO) |=> !out_bit_ff)
		else $error("zero source gave a one");
	AST_SRC_UNKNOWN: assert property ((s_move_bit ##0 (src_ff == '0 ||
		(src_ff > 5'(NUM_BLOCKS) && src_ff < SRC_CONST_LOW))) |=> !out_bit_ff)
		else $error("unassigned source gave a one");

	// ----------------------------------------
	// Arithmetic checks
	// ----------------------------------------
	// Carry seeding
	AST_CARRY_SEED_ADD: assert property ((bit_stb && add_op && bit_idx == FIRST_BIT) |-> !carry_in)
		else $error("add did not start with a clear carry");
	AST_CARRY_SEED_SUB: assert property ((bit_stb && sub_op && bit_idx == FIRST_BIT) |-> carry_in)
		else $error("subtract did not start with a set carry");
	// Serial bits and hold
	AST_ACC_SUB_REST: assert property ((s_move_bit ##0 sub_op && bit_idx != FIRST_BIT) |=>
		short_accumulator_ff[$past(bit_idx)] == ($past(acc_bit) ^ ~$past(src_bit) ^ $past(carry_ff)))
		else $error("serial subtract bit wrong");
	AST_ACC_HOLD: assert property ((bit_stb && !acc_wr) |=>
		short_accumulator_ff == $past(short_accumulator_ff))
		else $error("short accumulator changed with no accumulator destination");

endmodule : cyclic_serial_word_store

//--- hw/serial_store_pkg.sv
// Constants, codes and carrier types for the cyclic serial word store.
// Assumes one 20 MHz clock and a control unit that sends transfer commands.
//
// What this block does
// - Words move serially, one bit per microsecond, 32 bits per slot.
// - 32 slots form a major cycle; slot counter 0..31 times everything.
// - Four single-word stores 13..16, readable and writable every slot.
// - A fifth single-word store holds each instruction word for control.
// - Double stores 19..21; suffix 2 in even slots, suffix 3 in odd.
// - Quad stores 17, 18; position k only in slots where slot mod 4 is k.
// - Twelve long stores of 32 words; word m only in slot m.
// - Each of 21 blocks has one shared source and one shared destination.
// - A write to a multi-word block changes only the position of that slot.
// - Each command is a 5-bit source and a 5-bit destination.
// - Sources 27..31 give bit 1, bit 17, bit 32, zero, all ones.
// - Constant sources 27..31 are usable in every slot.
// - Add and subtract happen only in the short accumulator, in any slot.
// - Destination 13 plainly overwrites the short accumulator.
// - Destination 25 adds the word into the short accumulator.
// - Destination 26 subtracts the word from the short accumulator.
// - Destinations 25 and 26 accept words in every slot.
package serial_store_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int BIT_TIME_NS   = 1000;
	localparam int BIT_CLKS      = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WORD_BITS     = 32;
	localparam int SLOTS         = 32;
	localparam logic [4:0] LAST_BIT  = 5'h1f;
	localparam logic [4:0] LAST_SLOT = 5'h1f;
	localparam logic [4:0] FIRST_BIT = 5'h00;

	// ----------------------------------------
	// Block, source and destination codes
	// ----------------------------------------
	localparam int NUM_BLOCKS  = 21;
	localparam int LAST_LONG   = 12;
	localparam int FIRST_QUAD  = 17;
	localparam int FIRST_DUAL  = 19;
	localparam int LONG_WORDS  = 32;
	localparam int QUAD_WORDS  = 4;
	localparam int DUAL_WORDS  = 2;
	localparam logic [4:0] BLK_SHORT_ACC  = 5'h0d;
	localparam logic [4:0] DST_ADD        = 5'h19;
	localparam logic [4:0] DST_SUB        = 5'h1a;
	localparam logic [4:0] SRC_CONST_LOW  = 5'h1b;
	localparam logic [4:0] SRC_CONST_MID  = 5'h1c;
	localparam logic [4:0] SRC_CONST_TOP  = 5'h1d;
	localparam logic [4:0] SRC_CONST_ZERO = 5'h1e;
	localparam logic [4:0] SRC_CONST_ONES = 5'h1f;

	// ----------------------------------------
	// Constant words
	// ----------------------------------------
	localparam logic [31:0] BIT_ONE_WORD        = 32'h0000_0001;
	localparam logic [31:0] BIT_SEVENTEEN_WORD  = 32'h0001_0000;
	localparam logic [31:0] BIT_THIRTY_TWO_WORD = 32'h8000_0000;
	localparam logic [31:0] ZERO_WORD           = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES_WORD       = 32'hffff_ffff;

	// Instruction word layout
	typedef struct packed {
		logic [15:0] spare;     // Unused, held with the word
		logic        slot_qual; // Move only in the named slot
		logic [4:0]  slot;      // Named slot
		logic [4:0]  dst;       // Destination code
		logic [4:0]  src;       // Source code
	} cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_MOVE = 2'b10
	} move_state_t;

	// Words held by a numbered block
	function automatic int block_words(input int blk);
		if (blk <= LAST_LONG) begin
			return LONG_WORDS;
		end else if (blk >= FIRST_DUAL) begin
			return DUAL_WORDS;
		end else if (blk >= FIRST_QUAD) begin
			return QUAD_WORDS;
		end
		return 1;
	endfunction : block_words

endpackage : serial_store_pkg

//--- hw/slot_timer.sv
// Bit period divider and bit/slot counters.
// Assumes mclk at the rate named in the package.
`timescale 1ns/100ps
module slot_timer #(
	parameter int BIT_CLKS = serial_store_pkg::BIT_CLKS
) (
	input  wire logic       mclk,    // System clock
	input  wire logic       rst,     // Async reset, high
	output logic            bit_stb, // Last clock of a bit period
	output logic [4:0]      bit_idx, // Bit within slot, lsb first
	output logic [4:0]      slot     // Word slot number
);
	import serial_store_pkg::*;

	localparam int DW = $clog2(BIT_CLKS + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CLKS - 1);

	logic [DW-1:0] div_ff;
	logic [4:0]    bit_ff;
	logic [4:0]    slot_ff;

	assign bit_stb = (div_ff == DIV_LAST);
	assign bit_idx = bit_ff;
	assign slot    = slot_ff;

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	// slot count wraps at 32
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_ff  <= '0;
			bit_ff  <= FIRST_BIT;
			slot_ff <= 5'h00;
		end else begin
			div_ff <= bit_stb ? '0 : div_ff + DW'(1);
			if (bit_stb) begin
				bit_ff <= bit_ff + 5'h01;
				if (bit_ff == LAST_BIT) begin
					slot_ff <= slot_ff + 5'h01;
				end
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_BIT_SPACING: assert property (bit_stb |-> ##20 bit_stb)
		else $error("bit period is not twenty clocks");
	AST_SLOT_STEP: assert property ((bit_stb && bit_ff == LAST_BIT) |=>
		(slot_ff == $past(slot_ff) + 5'h01) && (bit_ff == FIRST_BIT))
		else $error("slot did not advance after last bit");

endmodule : slot_timer

//--- hw/word_block.sv
// One circulating storage block of WORDS words, one serial port each way.
// Assumes bit strobe, bit index and slot from the slot timer.
`timescale 1ns/100ps
module word_block #(
	parameter int WORDS = 1
) (
	input  wire logic       mclk,    // System clock
	input  wire logic       rst,     // Async reset, high
	input  wire logic       bit_stb, // Bit period strobe
	input  wire logic [4:0] bit_idx, // Bit within slot
	input  wire logic [4:0] slot,    // Current slot
	input  wire logic       wr_en,   // Destination open
	input  wire logic       wr_bit,  // Serial word in
	output logic            rd_bit   // Serial word out
);
	import serial_store_pkg::*;

	localparam int PW = (WORDS > 1) ? $clog2(WORDS) : 1;

	logic [31:0]   mem_ff [WORDS];
	logic [PW-1:0] pos;

	// quad position is slot mod 4
	assign pos    = (WORDS > 1) ? slot[PW-1:0] : '0;
	assign rd_bit = mem_ff[pos][bit_idx];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// only the slot's position written
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_ff[i] <= ZERO_WORD;
			end
		end else if (bit_stb && wr_en) begin
			mem_ff[pos][bit_idx] <= wr_bit;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_POS_WRITE: assert property ((bit_stb && wr_en) |=>
		mem_ff[$past(pos)][$past(bit_idx)] == $past(wr_bit))
		else $error("serial bit not stored in slot position");
	AST_POS_HOLD: assert property ((bit_stb && !wr_en) |=>
		mem_ff[$past(pos)] == $past(mem_ff[pos]))
		else $error("word changed with destination closed");

endmodule : word_block

//--- verification/control_unit_model.sv
// Control unit model: offers one transfer command at a time to the store.
// Assumes cmd_ready is a one-clock pulse sampled on the rising mclk edge.
`timescale 1ns/100ps
module control_unit_model (
	input  wire logic              mclk,      // System clock
	input  wire logic              cmd_ready, // Command taken now
	output serial_store_pkg::cmd_t cmd_word,  // Offered command
	output logic                   cmd_valid  // Command offered
);
	import serial_store_pkg::*;

	// Idle lines at time zero
	initial begin
		cmd_word  = '0;
		cmd_valid = 1'b0;
	end

	// paired codes, named slot
	// Offer after some idle clocks, hold until taken, then release
	task automatic issue(input cmd_t c, input int gap, output bit taken);
		int n;
		taken = 1'b0;
		repeat (gap + 1) @(negedge mclk);
		cmd_word  = c;
		cmd_valid = 1'b1;
		for (n = 0; n < 40000 && !taken; n++) begin
			@(posedge mclk);
			taken = (cmd_ready === 1'b1);
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
		cmd_word  = ~c;
	endtask : issue
endmodule : control_unit_model

//--- verification/cyclic_serial_word_store_bench.sv
// Self-checking bench for the cyclic serial word store.
// Assumes a 20 MHz mclk, full 20-clock bit periods and the control unit model.
`timescale 1ns/100ps
module cyclic_serial_word_store_bench;
	import serial_store_pkg::*;

	// ----------------------------------------
	// Clock, reset, wiring
	// ----------------------------------------
	logic        mclk;
	logic        rst;
	cmd_t        cmd_word;
	logic        cmd_valid;
	logic        cmd_ready;
	logic        busy;
	logic        bit_stb;
	logic [4:0]  bit_idx;
	logic [4:0]  slot;
	logic        out_bit_ff;
	logic [31:0] instr_word_ff;
	logic [31:0] short_accumulator_ff;
	logic [31:0] mem [1:21][0:31];
	int          fail_count;
	int          check_count;

	// Free-running clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	cyclic_serial_word_store #(.BIT_CLKS(20)) i_cyclic_serial_word_store (
		.mclk                 (mclk),
		.rst                  (rst),
		.cmd_word             (cmd_word),
		.cmd_valid            (cmd_valid),
		.cmd_ready            (cmd_ready),
		.busy                 (busy),
		.bit_stb              (bit_stb),
		.bit_idx              (bit_idx),
		.slot                 (slot),
		.out_bit_ff           (out_bit_ff),
		.instr_word_ff        (instr_word_ff),
		.short_accumulator_ff (short_accumulator_ff)
	);

	control_unit_model i_control_unit_model (
		.mclk      (mclk),
		.cmd_ready (cmd_ready),
		.cmd_word  (cmd_word),
		.cmd_valid (cmd_valid)
	);

	// ----------------------------------------
	// Reference store model and helpers
	// ----------------------------------------
	function automatic int depth(input int b);
		return (b <= 12) ? 32 : (b >= 19) ? 2 : (b >= 17) ? 4 : 1;
	endfunction : depth

	// Word a source emits in slot p
	function automatic logic [31:0] src_word(input int s, input int p);
		case (s)
			27: return 32'h0000_0001;
			28: return 32'h0001_0000;
			29: return 32'h8000_0000;
			30: return 32'h0000_0000;
			31: return 32'hffff_ffff;
			default: return (s >= 1 && s <= 21) ? mem[s][p % depth(s)] : 32'h0000_0000;
		endcase
	endfunction : src_word

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// One transfer: issue, collect the serial source word, compare results
	task automatic move(input int s, input int d, input bit q, input int ms, input int gap);
		cmd_t        c;
		bit          ok;
		logic [31:0] sw;
		logic [31:0] got;
		int          k;
		int          n;
		int          p;
		c = {16'ha5c3, q, 5'(ms), 5'(d), 5'(s)};
		i_control_unit_model.issue(c, gap, ok);
		check(32'(ok), 32'h1);
		check(32'(busy), 32'h1);
		check(32'(bit_idx), 32'h0);
		check(instr_word_ff, c);
		p = int'(slot);
		if (q) check(32'(slot), 32'(ms));
		sw = src_word(s, p);
		for (k = 0; k < 32; k++) begin
			n = 0;
			do begin
				@(negedge mclk);
				n++;
			end while (bit_stb !== 1'b1 && n < 100);
			@(negedge mclk);
			got[k] = out_bit_ff;
		end
		check(got, sw);
		check(32'(busy), 32'h0);
		if (d >= 1 && d <= 21) mem[d][p % depth(d)] = sw;
		else if (d == 25) mem[13][0] = mem[13][0] + sw;
		else if (d == 26) mem[13][0] = mem[13][0] - sw;
		check(short_accumulator_ff, mem[13][0]);
	endtask : move

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		check({busy, cmd_ready, bit_stb, out_bit_ff, bit_idx, slot}, 32'h0);
		check(instr_word_ff, 32'h0);
		check(short_accumulator_ff, 32'h0);
	endtask : t_reset

	task automatic t_timing;
		int n;
		logic [4:0] s0;
		n = 0;
		do @(negedge mclk); while (bit_stb !== 1'b1);
		do begin
			@(negedge mclk);
			n++;
		end while (bit_stb !== 1'b1 && n < 100);
		check(32'(n), 32'h0000_0014);
		@(negedge mclk);
		s0 = slot;
		do @(negedge mclk); while (slot === s0);
		s0 = slot;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (slot === s0 && n < 2000);
		check(32'(n), 32'h0000_0280);
		check(32'(slot), 32'(5'(s0 + 5'h01)));
	endtask : t_timing

	task automatic t_multi;
		move(27, 19, 1, 4, 0);
		move(28, 19, 1, 7, 0);
		move(19, 13, 1, 10, 0);
		move(19, 14, 1, 13, 0);
		move(14, 13, 1, 15, 0);
		move(31, 17, 1, 17, 0);
		move(17, 13, 1, 20, 0);
		move(17, 13, 1, 21, 0);
		move(29, 8, 1, 24, 0);
		move(8, 13, 1, 27, 0);
		move(8, 13, 1, 24, 0);
	endtask : t_multi

	task automatic t_consts;
		int c;
		for (c = 27; c <= 31; c++) begin
			move(c, 13, 0, 0, c[0] ? 640 : 0);
		end
	endtask : t_consts

	task automatic t_arith;
		move(27, 13, 0, 0, 0);
		move(13, 25, 0, 0, 0);
		move(13, 25, 0, 0, 640);
		move(27, 25, 0, 0, 0);
		check(short_accumulator_ff, 32'h0000_0005);
		move(13, 14, 0, 0, 0);
		move(30, 13, 0, 0, 0);
		move(14, 26, 0, 0, 640);
		check(short_accumulator_ff, 32'hffff_fffb);
		move(31, 13, 0, 0, 0);
		move(27, 25, 0, 0, 0);
		check(short_accumulator_ff, 32'h0000_0000);
		move(27, 26, 0, 0, 0);
		check(short_accumulator_ff, 32'hffff_ffff);
		move(22, 13, 0, 0, 0);
		move(27, 22, 0, 0, 0);
		check(short_accumulator_ff, 32'h0000_0000);
	endtask : t_arith

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		int b;
		int w;
		fail_count  = 0;
		check_count = 0;
		rst         = 1'b1;
		for (b = 1; b <= 21; b++) begin
			for (w = 0; w < 32; w++) begin
				mem[b][w] = 32'h0;
			end
		end
		repeat (16) @(negedge mclk);
		t_reset;
		rst = 1'b0;
		t_timing;
		t_multi;
		t_consts;
		t_arith;
		test_done;
	end

	// Cut a hang short
	initial begin
		repeat (95000) @(posedge mclk);
		fail_count++;
		test_done;
	end
endmodule : cyclic_serial_word_store_bench
